/* hdl/qib_host_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "qib_cfg.svh"

// Summary of operation
// - Threshold compares only upper six bid bits
// - Equal bids favour highest channel, D strongest
// - Nonzero level setting delays bidding until fill
// - Level zero: empty receiver, full transmitter silent
// - Each of 16 channel sources gated by mask, timers by priority B bits
// - Format 00 gives full programmed vector
// - Format 01 puts channel in low bits
// - Format 10 gives three bits, type, channel
// - Format 11 drives all ones
// - Captured source holds count or priority, type, channel
// - Control register: threshold high, format low
// - Write 27h enables, 26h disables acknowledge
// - Reset enables data acknowledge
// - Acknowledge mode writes at ack or end
// - Acknowledge follows two clock edges after start
// - Acknowledge marks read data or write done
// - Interrupt acknowledge captures winner, drives vector
// - Plain mode writes at strobe trailing edge
// - Plain read drives at start, ends on rise
// - Command 2Ah captures winner into captured source
// - Request output never captures the winner
// - Bids compared each clock, request above threshold
// - Identity bits encode the source type
module qib_host_port
  import qib_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        chip_enable_n_in,
  input  wire logic        read_strobe_n_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        interrupt_acknowledge_n_in,
  input  wire logic [5:0]  addr_in,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_out,
  output logic             data_acknowledge_n_out,
  output logic             data_acknowledge_n_oe_out,
  output logic             interrupt_request_n_out,
  output logic             interrupt_request_n_oe_out,
  input  wire logic [15:0] rx_fill_in,
  input  wire logic [3:0]  rx_error_in,
  input  wire logic [15:0] tx_fill_in,
  input  wire logic [3:0]  break_in,
  input  wire logic [3:0]  cos_in,
  input  wire logic [1:0]  ct_done_in
);

  // ----------------------------------------------------------------
  // State and reset image
  // ----------------------------------------------------------------
  localparam qib_port_t RST = '{
    st:      QIB_IDLE,
    kind:    QIB_RD,
    intctl:  `QIB_INTCTL_RST,
    vecbase: `QIB_VECBASE_RST,
    dack_en: 1'b1,
    dack_n:  1'b1,
    irq_n:   1'b1,
    default: '0
  };
  localparam logic [1:0] DACK_LAST = 2'(`QIB_DACK_EDGES - 1);

  qib_port_t                r;
  qib_port_t                n;
  logic                     ce_rd;
  logic                     ce_wr;
  logic                     ia;
  logic                     act;
  logic                     commit;
  logic [`QIB_NSRC-1:0][7:0] bid;
  logic [`QIB_NSRC-1:0]      bid_ok;
  logic [7:0]               arb_win;
  logic                     arb_irq;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // FIFO level check against the programmed setting
  function automatic logic lvl_ok(input logic [3:0] fill, input logic [1:0] lvl,
                                  input logic tx);
    logic [15:0] tab;
    logic [3:0]  lim;
    tab = tx ? `QIB_TX_LIM : `QIB_RX_NEED;
    lim = tab[{lvl, 2'h0} +: 4];
    lvl_ok = tx ? (fill <= lim) : (fill >= lim);
  endfunction : lvl_ok

  // Byte count squeezed to three bits, one to eight
  function automatic logic [2:0] cnt3(input logic [3:0] v);
    cnt3 = (v == 4'h0) ? 3'h0 : 3'(v - 4'h1);
  endfunction : cnt3

  // Vector built from the winning bid
  function automatic logic [7:0] vec(input logic [1:0] fmt, input logic [7:0] iv,
                                     input logic [7:0] w);
    case (fmt)
      `QIB_FMT_FULL: vec = iv;
      `QIB_FMT_CHAN: vec = {iv[7:2], w[1:0]};
      `QIB_FMT_TYPE: vec = {iv[7:5], w[4:2], w[1:0]};
      default:       vec = `QIB_VEC_INHIBIT;
    endcase
  endfunction : vec

  // Register read image
  function automatic logic [7:0] rd_mux(input qib_port_t s, input logic [5:0] a);
    case (a)
      `QIB_ADR_INTCTL:  rd_mux = s.intctl;
      `QIB_ADR_VECBASE: rd_mux = s.vecbase;
      `QIB_ADR_CAPSRC:  rd_mux = s.capsrc;
      `QIB_ADR_MASK_AB: rd_mux = s.intmask[7:0];
      `QIB_ADR_MASK_CD: rd_mux = s.intmask[15:8];
      `QIB_ADR_PRIO_A:  rd_mux = {2'h0, s.prio_a};
      `QIB_ADR_PRIO_B:  rd_mux = {3'h0, s.prio_b};
      default: begin
        if ((a & `QIB_ADR_LVL_MSK) == `QIB_ADR_LVL) begin
          rd_mux = {4'h0, s.lvl[{a[1:0], 2'h0} +: 4]};
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  endfunction : rd_mux

  // ----------------------------------------------------------------
  // Bid formation for the 18 sources
  // ----------------------------------------------------------------
  // Order: receivers, transmitters, breaks, state changes, timers
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      bid[c] = {cnt3(rx_fill_in[c*4 +: 4]), rx_error_in[c], `QIB_ID_RX, 2'(c)};
      bid_ok[c] = r.intmask[c*4] &&
                  lvl_ok(rx_fill_in[c*4 +: 4], r.lvl[c*4 +: 2], 1'b0);
      bid[4+c] = {1'b0, cnt3(`QIB_FIFO_DEPTH - tx_fill_in[c*4 +: 4]), `QIB_ID_TX,
                  2'(c)};
      bid_ok[4+c] = r.intmask[c*4+1] &&
                    lvl_ok(tx_fill_in[c*4 +: 4], r.lvl[c*4+2 +: 2], 1'b1);
      bid[8+c] = {r.prio_a[5:3], `QIB_ID_BRK, 2'(c)};
      bid_ok[8+c] = r.intmask[c*4+2] && break_in[c];
      bid[12+c] = {r.prio_a[2:0], `QIB_ID_COS, 2'(c)};
      bid_ok[12+c] = r.intmask[c*4+3] && cos_in[c];
    end
    for (int t = 0; t < 2; t++) begin
      bid[16+t] = {r.prio_b[2:0], `QIB_ID_CT, 2'(t)};
      bid_ok[16+t] = r.prio_b[3+t] && ct_done_in[t];
    end
  end

  // Compare with threshold at the clock rate
  qib_bid_arbiter #(
    .NSRC(`QIB_NSRC)
  ) u_arb (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .bid_in     (bid),
    .bid_ok_in  (bid_ok),
    .thresh_in  (r.intctl[`QIB_THR_MSB:`QIB_THR_LSB]),
    .win_out    (arb_win),
    .irq_out    (arb_irq)
  );

  // ----------------------------------------------------------------
  // Host bus cycle decode
  // ----------------------------------------------------------------
  // Read and write strobes combine with the chip enable; interrupt acknowledge stands alone; each cycle lives while its own input holds
  always_comb begin
    ce_rd = !chip_enable_n_in && !read_strobe_n_in;
    ce_wr = !chip_enable_n_in && !write_strobe_n_in;
    ia    = !interrupt_acknowledge_n_in;
    act   = ((r.kind == QIB_RD) && ce_rd) ||
            ((r.kind == QIB_WR) && ce_wr) ||
            ((r.kind == QIB_IA) && ia);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n      = r;
    commit = 1'b0;
    // Request follows the arbiter only; capture is never tied to it
    n.irq   = arb_irq;
    n.irq_n = !arb_irq;
    unique case (r.st)
      QIB_IDLE: begin
        n.cnt = 2'h0;
        if (ia) begin
          n.kind   = QIB_IA;
          n.st     = QIB_WAIT;
          n.capsrc = arb_win;
          n.dout   = vec(r.intctl[1:0], r.vecbase, arb_win);
          n.doe    = 1'b1;
        end else if (ce_wr) begin
          n.kind  = QIB_WR;
          n.st    = QIB_WAIT;
          n.addr  = addr_in;
          n.wdata = data_in;
        end else if (ce_rd) begin
          n.kind = QIB_RD;
          n.st   = QIB_WAIT;
          n.addr = addr_in;
          n.dout = rd_mux(r, addr_in);
          n.doe  = 1'b1;
        end
      end
      QIB_WAIT: begin
        if ((r.kind == QIB_WR) && act) begin
          n.wdata = data_in;
        end
        if (!act) begin
          // Strobe rose first: write lands here in either style
          n.st   = QIB_IDLE;
          n.doe  = 1'b0;
          commit = (r.kind == QIB_WR);
        end else if (r.dack_en && (r.cnt == DACK_LAST)) begin
          // Acknowledge falls as the write lands
          n.st     = QIB_HOLD;
          n.dack   = 1'b1;
          n.dack_n = 1'b0;
          commit   = (r.kind == QIB_WR);
        end else if (r.dack_en) begin
          n.cnt = r.cnt + 2'h1;
        end
      end
      QIB_HOLD: begin
        if (!act) begin
          n.st     = QIB_IDLE;
          n.dack   = 1'b0;
          n.dack_n = 1'b1;
          n.doe    = 1'b0;
        end
      end
    endcase
    // Register write effects
    if (commit) begin
      case (r.addr)
        `QIB_ADR_INTCTL:   n.intctl = r.wdata;
        `QIB_ADR_VECBASE:  n.vecbase = r.wdata;
        `QIB_ADR_MASK_AB:  n.intmask[7:0] = r.wdata;
        `QIB_ADR_MASK_CD:  n.intmask[15:8] = r.wdata;
        `QIB_ADR_PRIO_A:   n.prio_a = r.wdata[5:0];
        `QIB_ADR_PRIO_B:   n.prio_b = r.wdata[4:0];
        `QIB_ADR_DACK_OFF: n.dack_en = 1'b0;
        `QIB_ADR_DACK_ON:  n.dack_en = 1'b1;
        `QIB_ADR_UPD:      n.capsrc = arb_win;
        default: begin
          if ((r.addr & `QIB_ADR_LVL_MSK) == `QIB_ADR_LVL) begin
            n.lvl[{r.addr[1:0], 2'h0} +: 4] = r.wdata[3:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign data_out                   = r.dout;
  assign data_oe_out                = r.doe;
  assign data_acknowledge_n_out     = r.dack_n;
  assign data_acknowledge_n_oe_out  = r.dack;
  assign interrupt_request_n_out    = r.irq_n;
  assign interrupt_request_n_oe_out = r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_dack_begin;
    (r.st == QIB_IDLE) && (ia || ce_wr || ce_rd) && r.dack_en ##1 act [*2];
  endsequence

  sequence s_iack;
    (r.st == QIB_IDLE) && ia;
  endsequence

  a_dack_two_edges: assert property (s_dack_begin |=> !r.dack_n && r.dack)
    else $error("acknowledge not asserted after two edges");

  a_dack_not_early: assert property (
    (r.st == QIB_IDLE) && (ia || ce_wr || ce_rd) |=> r.dack_n [*2])
    else $error("acknowledge asserted too early");

  a_dack_reset_on: assert property ($rose(nrst_in) |-> r.dack_en)
    else $error("acknowledge not enabled after reset");

  a_dack_cmd_off: assert property (
    commit && (r.addr == `QIB_ADR_DACK_OFF) |=> !r.dack_en)
    else $error("acknowledge still enabled after disable write");

  a_dack_write_at: assert property (
    (r.st == QIB_WAIT) && (r.kind == QIB_WR) && act && r.dack_en &&
    (r.cnt == DACK_LAST) |-> commit)
    else $error("write did not land with acknowledge");

  a_sync_write_end: assert property (
    (r.st == QIB_WAIT) && (r.kind == QIB_WR) && !act |-> commit ##1 (r.st == QIB_IDLE))
    else $error("write did not land at strobe end");

  a_read_drive: assert property (
    (r.st == QIB_IDLE) && !ia && !ce_wr && ce_rd |=> r.doe ##1 (r.doe || !act))
    else $error("read data not driven from cycle start");

  a_read_release: assert property (
    (r.kind == QIB_RD) && (r.st != QIB_IDLE) && !act |=> !r.doe)
    else $error("read data not released at strobe rise");

  a_iack_capture: assert property (
    s_iack |=> (r.capsrc == $past(arb_win)) && r.doe)
    else $error("acknowledge did not capture winner");

  a_vec_chan: assert property (
    (s_iack and (r.intctl[1:0] == `QIB_FMT_CHAN)) |=>
    (r.dout[1:0] == $past(arb_win[1:0])) && (r.dout[7:2] == r.vecbase[7:2]))
    else $error("vector channel substitution wrong");

  a_vec_inhibit: assert property (
    (s_iack and (r.intctl[1:0] == 2'h3)) |=> (r.dout == `QIB_VEC_INHIBIT))
    else $error("inhibited vector not all ones");

  a_update_cmd: assert property (
    commit && (r.addr == `QIB_ADR_UPD) |=> (r.capsrc == $past(arb_win)))
    else $error("update command did not capture winner");

  a_capture_hold: assert property (
    !(commit && (r.addr == `QIB_ADR_UPD)) && !((r.st == QIB_IDLE) && ia) |=> $stable(r.capsrc))
    else $error("captured source changed without acknowledge or command");

endmodule : qib_host_port
`default_nettype wire

/* hdl/qib_cfg.svh */
`ifndef QIB_CFG_SVH
`define QIB_CFG_SVH

// ----------------------------------------------------------------
// Register offsets on the host port
// ----------------------------------------------------------------
`define QIB_ADR_INTCTL   6'h20
`define QIB_ADR_VECBASE  6'h21
`define QIB_ADR_CAPSRC   6'h22
`define QIB_ADR_MASK_AB  6'h23
`define QIB_ADR_MASK_CD  6'h24
`define QIB_ADR_PRIO_A   6'h25
`define QIB_ADR_DACK_OFF 6'h26
`define QIB_ADR_DACK_ON  6'h27
`define QIB_ADR_PRIO_B   6'h28
`define QIB_ADR_UPD      6'h2A
`define QIB_ADR_LVL      6'h2C
`define QIB_ADR_LVL_MSK  6'h3C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define QIB_THR_MSB      7
`define QIB_THR_LSB      2
`define QIB_INTCTL_RST   8'h00
`define QIB_VECBASE_RST  8'h0F
`define QIB_FMT_FULL     2'h0
`define QIB_FMT_CHAN     2'h1
`define QIB_FMT_TYPE     2'h2
`define QIB_VEC_INHIBIT  8'hFF

// ----------------------------------------------------------------
// Bid identity codes, FIFO limits and timing
// ----------------------------------------------------------------
`define QIB_ID_RX        2'h3
`define QIB_ID_TX        2'h2
`define QIB_ID_BRK       3'h4
`define QIB_ID_COS       3'h1
`define QIB_ID_CT        3'h5
`define QIB_NSRC         18
`define QIB_FIFO_DEPTH   4'h8
`define QIB_RX_NEED      16'h8631
`define QIB_TX_LIM       16'h0257
`define QIB_DACK_EDGES   2

`endif

/* hdl/qib_pkg.sv */
package qib_pkg;

  // ----------------------------------------------------------------
  // Bus cycle states and kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    QIB_IDLE = 3'h1,
    QIB_WAIT = 3'h2,
    QIB_HOLD = 3'h4
  } qib_state_t;

  typedef enum logic [2:0] {
    QIB_RD = 3'h1,
    QIB_WR = 3'h2,
    QIB_IA = 3'h4
  } qib_kind_t;

  // ----------------------------------------------------------------
  // Whole state of the host port
  // ----------------------------------------------------------------
  typedef struct packed {
    qib_state_t  st;
    qib_kind_t   kind;
    logic [5:0]  addr;
    logic [1:0]  cnt;
    logic [7:0]  wdata;
    logic [7:0]  intctl;
    logic [7:0]  vecbase;
    logic [7:0]  capsrc;
    logic [15:0] intmask;
    logic [15:0] lvl;
    logic [5:0]  prio_a;
    logic [4:0]  prio_b;
    logic        dack_en;
    logic [7:0]  dout;
    logic        doe;
    logic        dack;
    logic        dack_n;
    logic        irq;
    logic        irq_n;
  } qib_port_t;

  // Whole state of the bid arbiter
  typedef struct packed {
    logic [7:0] win;
    logic       irq;
  } qib_arb_t;

endpackage : qib_pkg

/* hdl/qib_bid_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "qib_cfg.svh"

module qib_bid_arbiter
  import qib_pkg::*;
#(
  parameter int NSRC = `QIB_NSRC
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 nrst_in,
  input  wire logic [NSRC-1:0][7:0] bid_in,
  input  wire logic [NSRC-1:0]      bid_ok_in,
  input  wire logic [5:0]           thresh_in,
  output logic      [7:0]           win_out,
  output logic                      irq_out
);

  qib_arb_t r;
  qib_arb_t n;

  // ----------------------------------------------------------------
  // Arbitration, evaluated every clock
  // ----------------------------------------------------------------
  // Full byte compare: equal upper fields fall to the higher channel
  always_comb begin
    n.win = 8'h00;
    for (int i = 0; i < NSRC; i++) begin
      if (bid_ok_in[i] && (bid_in[i] > n.win)) begin
        n.win = bid_in[i];
      end
    end
    n.irq = n.win[`QIB_THR_MSB:`QIB_THR_LSB] > thresh_in;
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign win_out = r.win;
  assign irq_out = r.irq;

  // Request level agrees with the winner and the threshold it met
  a_irq_thresh_top: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    ##1 (irq_out == (win_out[`QIB_THR_MSB:`QIB_THR_LSB] > $past(thresh_in))))
    else $error("request level disagrees with winner and threshold");

endmodule : qib_bid_arbiter
`default_nettype wire

/* tb/qib_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Host processor model on the device's parallel bus
// ----------------------------------------------------------------
module qib_host_model (
  input  wire logic       clk_in,
  input  wire logic       ack_pin_in,
  input  wire logic       data_oe_in,
  input  wire logic [7:0] rdata_in,
  output logic            ce_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            iack_n_out,
  output logic      [5:0] addr_out,
  output logic      [7:0] data_out
);
  // Bus idle at time zero
  initial begin
    ce_n_out   = 1'b1;
    rd_n_out   = 1'b1;
    wr_n_out   = 1'b1;
    iack_n_out = 1'b1;
    addr_out   = 6'h00;
    data_out   = 8'h00;
  end

  // One cycle: kind 0 read, 1 write, 2 vector fetch, 3 write whose data changes late
  // With ack, n is the edge count up to the edge that sees ack; without, acks seen
  task automatic cycle(input int kind, input logic [5:0] a, input logic [7:0] d,
                       input logic [7:0] d2, input bit ack,
                       output logic [7:0] q, output int n);
    int i;
    n = 0;
    q = 'x;
    @(negedge clk_in);
    addr_out   = a;
    data_out   = d;
    iack_n_out = !(kind == 2);
    rd_n_out   = !(kind == 0);
    wr_n_out   = !(kind == 1 || kind == 3);
    ce_n_out   = (kind == 2);
    // Request held steady until ack is sampled, or three edges without ack
    for (i = 1; i <= 20; i++) begin
      @(posedge clk_in);
      q = data_oe_in ? rdata_in : 'x;
      if (!ack_pin_in) n++;
      if (ack && !ack_pin_in) break;
      if (!ack && i == 3) break;
      if (kind == 3 && i == 1) begin
        @(negedge clk_in);
        data_out = d2;
      end
    end
    if (ack) n = (i > 20) ? -1 : i;
    // Release everything; the undriven bus shows the inverse of the last value
    @(negedge clk_in);
    ce_n_out   = 1'b1;
    rd_n_out   = 1'b1;
    wr_n_out   = 1'b1;
    iack_n_out = 1'b1;
    data_out   = ~data_out;
    repeat (2) @(negedge clk_in);
  endtask : cycle
endmodule : qib_host_model

`default_nettype wire

/* tb/qib_host_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "qib_cfg.svh"

module qib_host_port_test;
  logic        clk_sys_in;
  logic        nrst_in;
  logic        ce_n, rd_n, wr_n, iack_n;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata, q;
  logic        data_oe, ack_n, ack_oe, irq_n, irq_oe;
  logic [15:0] rx_fill, tx_fill;
  logic [3:0]  rx_err, brk, cs;
  logic [1:0]  ct;
  int          error_cnt, comparisons, f;
  bit          ack_on;
  logic [7:0]  vec [4] = '{8'hB4, 8'hB5, 8'hAD, 8'hFF};
  // Open-drain pins with pull-ups
  wire logic   ack_pin = !(ack_oe && !ack_n);
  wire logic   irq_pin = !(irq_oe && !irq_n);

  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  qib_host_port dut_u (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .chip_enable_n_in(ce_n),
    .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .interrupt_acknowledge_n_in(iack_n),
    .addr_in(addr), .data_in(wdata), .data_out(rdata), .data_oe_out(data_oe),
    .data_acknowledge_n_out(ack_n), .data_acknowledge_n_oe_out(ack_oe),
    .interrupt_request_n_out(irq_n), .interrupt_request_n_oe_out(irq_oe),
    .rx_fill_in(rx_fill), .rx_error_in(rx_err), .tx_fill_in(tx_fill),
    .break_in(brk), .cos_in(cs), .ct_done_in(ct)
  );

  qib_host_model host_u (
    .clk_in(clk_sys_in), .ack_pin_in(ack_pin), .data_oe_in(data_oe), .rdata_in(rdata),
    .ce_n_out(ce_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .iack_n_out(iack_n),
    .addr_out(addr), .data_out(wdata)
  );

  // ----------------------------------------------------------------
  // Report, compare and bus tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  task automatic cmp_cnt(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_cnt

  // Bus cycle; a wait that runs out ends the run
  task automatic bus(input int kind, input logic [5:0] a, input logic [7:0] d,
                     input logic [7:0] d2);
    int n;
    host_u.cycle(kind, a, d, d2, ack_on, q, n);
    if (n < 0) begin
      error_cnt++;
      $display("Error ack wait expected 4 seen timeout");
      test_done();
    end
    cmp_cnt("ack edge", ack_on ? 4 : 0, n);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1, a, d, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    bus(0, a, 8'h00, 8'h00);
    cmp8("read data", exp, q);
  endtask : rd

  // Apply source levels, issue the update command, read back the capture
  task automatic src(input logic [15:0] rx, input logic [3:0] er, input logic [15:0] tx,
                     input logic [3:0] b, input logic [3:0] c, input logic [1:0] t,
                     input logic [7:0] exp);
    @(negedge clk_sys_in);
    rx_fill = rx;
    rx_err  = er;
    tx_fill = tx;
    brk     = b;
    cs      = c;
    ct      = t;
    wr(`QIB_ADR_UPD, 8'h00);
    rd(`QIB_ADR_CAPSRC, exp);
  endtask : src

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_in     = 1'b0;
    rx_fill     = 16'h0000;
    rx_err      = 4'h0;
    tx_fill     = 16'h8888;
    brk         = 4'h0;
    cs          = 4'h0;
    ct          = 2'h0;
    ack_on      = 1'b1;
    error_cnt   = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    nrst_in = 1'b1;
    // Reset values, acknowledge on from reset, unmapped read
    rd(`QIB_ADR_INTCTL, 8'h00);
    rd(`QIB_ADR_VECBASE, 8'h0F);
    rd(`QIB_ADR_CAPSRC, 8'h00);
    rd(6'h10, 8'h00);
    wr(`QIB_ADR_MASK_AB, 8'hFF);
    wr(`QIB_ADR_MASK_CD, 8'hFF);
    wr(`QIB_ADR_PRIO_A, 8'h3A);
    wr(`QIB_ADR_PRIO_B, 8'h1B);
    // Each source type alone, then a tie between channels
    src(16'h0000, 4'h0, 16'h8888, 4'h0, 4'h0, 2'h0, 8'h00);
    src(16'h0000, 4'h0, 16'h8880, 4'h0, 4'h0, 2'h0, 8'h78);
    src(16'h0008, 4'h1, 16'h8888, 4'h0, 4'h0, 2'h0, 8'hFC);
    src(16'h0000, 4'h0, 16'h8888, 4'h1, 4'h0, 2'h0, 8'hF0);
    src(16'h0000, 4'h0, 16'h8888, 4'h0, 4'h4, 2'h0, 8'h46);
    src(16'h0000, 4'h0, 16'h8888, 4'h0, 4'h0, 2'h2, 8'h75);
    src(16'h3300, 4'h0, 16'h8888, 4'h0, 4'h0, 2'h0, 8'h4F);
    // Mask and fill level on channel D
    wr(`QIB_ADR_MASK_CD, 8'hEF);
    src(16'h3300, 4'h0, 16'h8888, 4'h0, 4'h0, 2'h0, 8'h4E);
    wr(`QIB_ADR_MASK_CD, 8'hFF);
    wr(`QIB_ADR_LVL + 6'h3, 8'h02);
    src(16'h3300, 4'h0, 16'h8888, 4'h0, 4'h0, 2'h0, 8'h4E);
    src(16'h6300, 4'h0, 16'h8888, 4'h0, 4'h0, 2'h0, 8'hAF);
    wr(`QIB_ADR_LVL + 6'h3, 8'h00);
    // Request against the six-bit threshold, capture untouched by the request
    @(negedge clk_sys_in);
    rx_fill = 16'h0030;
    wr(`QIB_ADR_INTCTL, 8'h48);
    cmp1("request pin", 1'b0, irq_pin);
    rd(`QIB_ADR_CAPSRC, 8'hAF);
    wr(`QIB_ADR_INTCTL, 8'h4C);
    cmp1("request pin", 1'b1, irq_pin);
    // Vector in all four formats
    wr(`QIB_ADR_VECBASE, 8'hB4);
    for (f = 0; f < 4; f++) begin
      wr(`QIB_ADR_INTCTL, {6'h00, 2'(f)});
      bus(2, 6'h00, 8'h00, 8'h00);
      cmp8("vector", vec[f], q);
      cmp1("data drive", 1'b0, data_oe);
    end
    rd(`QIB_ADR_CAPSRC, 8'h4D);
    // Acknowledge off: write lands with the data seen at strobe release
    wr(`QIB_ADR_DACK_OFF, 8'h00);
    ack_on = 1'b0;
    bus(3, `QIB_ADR_INTCTL, 8'h11, 8'h48);
    rd(`QIB_ADR_INTCTL, 8'h48);
    wr(`QIB_ADR_DACK_ON, 8'h00);
    ack_on = 1'b1;
    rd(`QIB_ADR_INTCTL, 8'h48);
    test_done();
  end
endmodule : qib_host_port_test

`default_nettype wire
